// [include/daqx_consts.svh]
/*
  constants of the extended control register set: offsets, field positions,
  reset values and burst timing; assumes a 50 MHz core clock.
// Contract
// - gain bits 1:0 select input range
// - upper gain bits never change burst rate
// - burst samples spaced at fixed rate
// - three counter data ports byte read/write
// - counter control port takes mode word
// - convert-disable 40h blocks, 00h allows starts
// - triggers honoured only in extended mode
// - reset leaves conversions allowed
// - burst-enable 40h on, 00h off
// - reset leaves burst trigger disabled
// - extended-mode 40h on, 00h off
// - reset leaves extended mode disabled
// - status at 407 read-only, shows settings
// - status resets to 000100xx
// - burst and extended flags report enables
// - conversion flag is inverse of disable
// - wait flag follows wait-state switch
// - clock flag one for 10 MHz source
// - burst length field sets conversions per trigger
*/
`ifndef DAQX_CONSTS_SVH
`define DAQX_CONSTS_SVH

`define DAQX_OFF_GAIN 12'h00b
`define DAQX_OFF_CTR0 12'h00c
`define DAQX_OFF_CTR1 12'h00d
`define DAQX_OFF_CTR2 12'h00e
`define DAQX_OFF_CTRL 12'h00f
`define DAQX_OFF_CDIS 12'h404
`define DAQX_OFF_BEN 12'h405
`define DAQX_OFF_MEN 12'h406
`define DAQX_OFF_STAT 12'h407

`define DAQX_EN_BIT 6
`define DAQX_ST_BURST 7
`define DAQX_ST_MODE 6
`define DAQX_ST_CONV 4
`define DAQX_ST_WAIT 1
`define DAQX_ST_CLK 0

`define DAQX_RST_GAIN 8'h00
`define DAQX_RST_BYTE 8'h00

`define DAQX_CLK_HZ 50000000
`define DAQX_BURST12_NS 4000
`define DAQX_BURST16_NS 13300
`define DAQX_BURST12_CYC ((`DAQX_BURST12_NS * (`DAQX_CLK_HZ / 1000000) + 999) / 1000)
`define DAQX_BURST16_CYC ((`DAQX_BURST16_NS * (`DAQX_CLK_HZ / 1000000) + 999) / 1000)

`endif

// [include/daqx_pkg.sv]
/*
  types of the extended control register set; uses nothing from daqx_consts.svh.
*/
package daqx_pkg;
    typedef enum logic [1:0] {
        DAQX_IDLE = 2'b00,
        DAQX_WAIT = 2'b01,
        DAQX_FIRE = 2'b10
    } daqx_burst_state_t;
endpackage : daqx_pkg

// [src/daqx_burst_pacer.sv]
/*
  burst pacer: after a trigger, issues a programmed number of conversion
  strobes at a fixed spacing. assumes one clock, trigger a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
`include "daqx_consts.svh"
module daqx_burst_pacer
    import daqx_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_trigger,
    input wire logic i_wide_variant,
    input wire logic [3:0] i_burst_length,
    output logic o_convert,
    output logic o_busy
);
    localparam logic [9:0] GAP12 = 10'(`DAQX_BURST12_CYC);
    localparam logic [9:0] GAP16 = 10'(`DAQX_BURST16_CYC);

    daqx_burst_state_t state_reg, state_next;
    logic [9:0] gap_reg, gap_next;
    logic [3:0] left_reg, left_next;
    logic convert_reg, convert_next;

    always_comb begin
        state_next = state_reg;
        gap_next = gap_reg;
        left_next = left_reg;
        convert_next = 1'b0;
        case (state_reg)
            DAQX_IDLE: begin
                if (i_trigger) begin
                    // length code n means n+1 samples (one to sixteen)
                    left_next = i_burst_length;
                    state_next = DAQX_FIRE;
                end
            end
            DAQX_FIRE: begin
                convert_next = 1'b1;
                // spacing depends only on variant, never on gain bits
                gap_next = (i_wide_variant ? GAP16 : GAP12) - 10'h001;
                state_next = (left_reg == 4'h0) ? DAQX_IDLE : DAQX_WAIT;
            end
            DAQX_WAIT: begin
                if (gap_reg <= 10'h001) begin
                    left_next = left_reg - 4'h1;
                    state_next = DAQX_FIRE;
                end else begin
                    gap_next = gap_reg - 10'h001;
                end
            end
            default: state_next = DAQX_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= DAQX_IDLE;
            gap_reg <= 10'h000;
            left_reg <= 4'h0;
            convert_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            gap_reg <= gap_next;
            left_reg <= left_next;
            convert_reg <= convert_next;
        end
    end

    assign o_convert = convert_reg;
    assign o_busy = (state_reg != DAQX_IDLE);
endmodule : daqx_burst_pacer
`default_nettype wire

// [src/daqx_ext_regs.sv]
/*
  upper control registers of the acquisition board: gain code, counter byte
  windows, write-only enable registers and burst status. assumes the host
  presents a one-cycle read or write strobe with the offset from base.
  counter internals live outside; their byte ports pass through here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "daqx_consts.svh"
module daqx_ext_regs
    import daqx_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_clk_sel_10mhz,
    input wire logic i_wait_state_sw,
    input wire logic i_wide_variant,
    input wire logic [3:0] i_burst_length_field,
    input wire logic i_trigger,
    input wire logic [7:0] i_ctr_rdata,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic [1:0] o_gain_code,
    output logic [1:0] o_ctr_sel,
    output logic o_ctr_wr,
    output logic o_ctr_rd,
    output logic o_ctrl_wr,
    output logic [7:0] o_ctr_wdata,
    output logic o_convert,
    output logic o_conv_enabled,
    output logic o_burst_busy
);
    logic [7:0] gain_code_reg, gain_code_next;
    logic conv_block_reg, conv_block_next;
    logic burst_en_reg, burst_en_next;
    logic ext_mode_reg, ext_mode_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic ctr_pend_reg, ctr_pend_next;
    logic [1:0] ctr_sel_reg, ctr_sel_next;
    logic ctr_wr_reg, ctr_wr_next;
    logic ctr_rd_reg, ctr_rd_next;
    logic ctrl_wr_reg, ctrl_wr_next;
    logic [7:0] ctr_wdata_reg, ctr_wdata_next;
    logic conv_en_reg, conv_en_next;
    logic convert_reg, convert_next;
    logic busy_reg, busy_next;
    logic trig_ok;
    logic burst_trig;
    logic single_trig;
    logic pace_convert;
    logic pace_busy;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic is_ctr(input logic [11:0] a);
        is_ctr = hit(a, `DAQX_OFF_CTR0) || hit(a, `DAQX_OFF_CTR1) || hit(a, `DAQX_OFF_CTR2);
    endfunction : is_ctr

    function automatic logic [1:0] ctr_index(input logic [11:0] a);
        ctr_index = 2'(a - `DAQX_OFF_CTR0);
    endfunction : ctr_index

    function automatic logic [7:0] status_byte(input logic b, input logic m, input logic c,
                                               input logic w, input logic k);
        logic [7:0] s;
        s = 8'h00;
        s[`DAQX_ST_BURST] = b;
        s[`DAQX_ST_MODE] = m;
        s[`DAQX_ST_CONV] = c;
        s[`DAQX_ST_WAIT] = w;
        s[`DAQX_ST_CLK] = k;
        status_byte = s;
    endfunction : status_byte

    // conversions need extended mode on and no block
    assign trig_ok = ext_mode_reg && !conv_block_reg;
    assign burst_trig = i_trigger && trig_ok && burst_en_reg && !pace_busy;
    assign single_trig = i_trigger && trig_ok && !burst_en_reg;

    daqx_burst_pacer u_pacer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_trigger(burst_trig),
        .i_wide_variant(i_wide_variant),
        .i_burst_length(i_burst_length_field),
        .o_convert(pace_convert),
        .o_busy(pace_busy)
    );

    always_comb begin
        gain_code_next = gain_code_reg;
        conv_block_next = conv_block_reg;
        burst_en_next = burst_en_reg;
        ext_mode_next = ext_mode_reg;
        if (i_wr) begin
            // full byte stored; only the two low bits drive the range
            if (hit(i_addr, `DAQX_OFF_GAIN)) gain_code_next = i_wdata;
            if (hit(i_addr, `DAQX_OFF_CDIS)) conv_block_next = i_wdata[`DAQX_EN_BIT];
            if (hit(i_addr, `DAQX_OFF_BEN)) burst_en_next = i_wdata[`DAQX_EN_BIT];
            if (hit(i_addr, `DAQX_OFF_MEN)) ext_mode_next = i_wdata[`DAQX_EN_BIT];
        end
    end

    always_comb begin
        ctr_wr_next = 1'b0;
        ctr_rd_next = 1'b0;
        ctrl_wr_next = 1'b0;
        ctr_sel_next = ctr_sel_reg;
        ctr_wdata_next = ctr_wdata_reg;
        ctr_pend_next = 1'b0;
        if (i_wr && is_ctr(i_addr)) begin
            ctr_wr_next = 1'b1;
            ctr_sel_next = ctr_index(i_addr);
            ctr_wdata_next = i_wdata;
        end
        if (i_wr && hit(i_addr, `DAQX_OFF_CTRL)) begin
            ctrl_wr_next = 1'b1;
            ctr_wdata_next = i_wdata;
        end
        if (i_rd && is_ctr(i_addr)) begin
            ctr_rd_next = 1'b1;
            ctr_sel_next = ctr_index(i_addr);
            ctr_pend_next = 1'b1;
        end
    end

    // read path: gain and status answer in one cycle, counters in two
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (ctr_pend_reg) begin
            rdata_next = i_ctr_rdata;
            rvalid_next = 1'b1;
        end else if (i_rd && !is_ctr(i_addr)) begin
            rvalid_next = 1'b1;
            if (hit(i_addr, `DAQX_OFF_GAIN)) begin
                rdata_next = gain_code_reg;
            end else if (hit(i_addr, `DAQX_OFF_STAT)) begin
                // the only view of the write-only enables
                rdata_next = status_byte(burst_en_reg, ext_mode_reg, !conv_block_reg,
                                         i_wait_state_sw, i_clk_sel_10mhz);
            end else begin
                // write-only and unmapped offsets read as zero
                rdata_next = 8'h00;
            end
        end
    end

    always_comb begin
        conv_en_next = trig_ok;
        // a block or mode-off written mid-burst stops the strobes at once
        convert_next = burst_en_reg ? (pace_convert && trig_ok) : single_trig;
        busy_next = pace_busy;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            gain_code_reg <= `DAQX_RST_GAIN;
            conv_block_reg <= 1'b0;
            burst_en_reg <= 1'b0;
            ext_mode_reg <= 1'b0;
        end else begin
            gain_code_reg <= gain_code_next;
            conv_block_reg <= conv_block_next;
            burst_en_reg <= burst_en_next;
            ext_mode_reg <= ext_mode_next;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= `DAQX_RST_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctr_pend_reg <= 1'b0;
            ctr_sel_reg <= 2'b00;
            ctr_wr_reg <= 1'b0;
            ctr_rd_reg <= 1'b0;
            ctrl_wr_reg <= 1'b0;
            ctr_wdata_reg <= `DAQX_RST_BYTE;
        end else begin
            ctr_pend_reg <= ctr_pend_next;
            ctr_sel_reg <= ctr_sel_next;
            ctr_wr_reg <= ctr_wr_next;
            ctr_rd_reg <= ctr_rd_next;
            ctrl_wr_reg <= ctrl_wr_next;
            ctr_wdata_reg <= ctr_wdata_next;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            conv_en_reg <= 1'b0;
            convert_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            conv_en_reg <= conv_en_next;
            convert_reg <= convert_next;
            busy_reg <= busy_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rdata_valid = rvalid_reg;
    assign o_gain_code = gain_code_reg[1:0];
    assign o_ctr_sel = ctr_sel_reg;
    assign o_ctr_wr = ctr_wr_reg;
    assign o_ctr_rd = ctr_rd_reg;
    assign o_ctrl_wr = ctrl_wr_reg;
    assign o_ctr_wdata = ctr_wdata_reg;
    assign o_convert = convert_reg;
    assign o_conv_enabled = conv_en_reg;
    assign o_burst_busy = busy_reg;
endmodule : daqx_ext_regs
`default_nettype wire

// [tb/daqx_ext_regs_properties.sv]
/*
  port checker of daqx_ext_regs, bound to every instance of it.
  assumes one-cycle host strobes and a 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "daqx_consts.svh"
module daqx_ext_regs_properties (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_trigger,
    input wire logic i_clk_sel_10mhz,
    input wire logic i_wait_state_sw,
    input wire logic i_wide_variant,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_ctr_rdata,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_ctr_wdata,
    input wire logic [3:0] i_burst_length_field,
    input wire logic [1:0] o_gain_code,
    input wire logic [1:0] o_ctr_sel,
    input wire logic o_rdata_valid,
    input wire logic o_ctr_wr,
    input wire logic o_ctr_rd,
    input wire logic o_ctrl_wr,
    input wire logic o_convert,
    input wire logic o_conv_enabled,
    input wire logic o_burst_busy
);
    wire logic [1:0] low2 = i_addr[1:0];
    wire logic [1:0] code = i_wdata[1:0];
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // the pacer gap is far longer than eight cycles, so this is a cheap lower bound
    sequence s_quiet;
        !o_convert [*8];
    endsequence
    sequence s_ctr_answer;
        o_ctr_rd && o_ctr_sel == 2'h1 ##1 o_rdata_valid && o_rdata == $past(i_ctr_rdata);
    endsequence
    property p_gain;
        i_wr && i_addr == `DAQX_OFF_GAIN |=> o_gain_code == $past(code);
    endproperty
    a_gain: assert property (p_gain) else $error("gain code not taken");
    property p_ctr_wr;
        i_wr && i_addr >= `DAQX_OFF_CTR0 && i_addr <= `DAQX_OFF_CTR2 |=>
            o_ctr_wr && o_ctr_sel == $past(low2) && o_ctr_wdata == $past(i_wdata);
    endproperty
    a_ctr_wr: assert property (p_ctr_wr) else $error("counter byte write lost");
    property p_ctr_rd;
        i_rd && i_addr == `DAQX_OFF_CTR1 |=> s_ctr_answer;
    endproperty
    a_ctr_rd: assert property (p_ctr_rd) else $error("counter byte read wrong");
    property p_ctrl;
        i_wr && i_addr == `DAQX_OFF_CTRL |=> o_ctrl_wr && !o_ctr_wr && o_ctr_wdata == $past(i_wdata);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control word lost");
    property p_status;
        i_rd && i_addr == `DAQX_OFF_STAT |=> o_rdata_valid && o_rdata[5] == 1'b0 &&
            o_rdata[1:0] == {$past(i_wait_state_sw), $past(i_clk_sel_10mhz)};
    endproperty
    a_status: assert property (p_status) else $error("status switches wrong");
    property p_wo_read;
        i_rd && i_addr >= `DAQX_OFF_CDIS && i_addr <= `DAQX_OFF_MEN |=> o_rdata_valid && o_rdata == 8'h00;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only place read back");
    property p_block;
        i_wr && i_addr == `DAQX_OFF_CDIS && i_wdata[6] |-> ##[1:2] !o_conv_enabled;
    endproperty
    a_block: assert property (p_block) else $error("block write ignored");
    property p_mode_off;
        i_wr && i_addr == `DAQX_OFF_MEN && !i_wdata[6] |-> ##[1:2] !o_conv_enabled;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode off ignored");
    property p_gap;
        o_convert && o_burst_busy |=> s_quiet;
    endproperty
    a_gap: assert property (p_gap) else $error("burst strobes too close");
    property p_conv_gate;
        o_convert |-> o_conv_enabled;
    endproperty
    a_conv_gate: assert property (p_conv_gate) else $error("convert strobe while blocked");
endmodule : daqx_ext_regs_properties
bind daqx_ext_regs daqx_ext_regs_properties u_props (.i_clock, .i_rst, .i_wr, .i_rd,
    .i_trigger, .i_clk_sel_10mhz, .i_wait_state_sw, .i_wide_variant, .i_addr, .i_wdata,
    .i_ctr_rdata, .o_rdata, .o_ctr_wdata, .i_burst_length_field, .o_gain_code, .o_ctr_sel,
    .o_rdata_valid, .o_ctr_wr, .o_ctr_rd, .o_ctrl_wr, .o_convert, .o_conv_enabled,
    .o_burst_busy);
`default_nettype wire

// [tb/daqx_ctr_model.sv]
/*
  stand-in for the external counter block: keeps one byte per counter.
  assumes the read strobe stands for one cycle and the byte is sampled then.
*/
`timescale 1ns/10ps
`default_nettype none
module daqx_ctr_model (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ctr_wr,
    input wire logic i_ctr_rd,
    input wire logic [1:0] i_ctr_sel,
    input wire logic [7:0] i_ctr_wdata,
    output logic [7:0] o_ctr_rdata
);
    logic [7:0] mem_reg [4];
    logic [7:0] last_reg;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            last_reg <= 8'h00;
        end else begin
            if (i_ctr_wr) mem_reg[i_ctr_sel] <= i_ctr_wdata;
            if (i_ctr_rd) last_reg <= mem_reg[i_ctr_sel];
        end
    end
    // outside the strobe the bus floats, so show the inverse and not the old byte
    assign o_ctr_rdata = i_ctr_rd ? mem_reg[i_ctr_sel] : ~last_reg;
endmodule : daqx_ctr_model
`default_nettype wire

// [tb/testbench.sv]
/*
  self-checking bench of daqx_ext_regs: host byte cycles, switches, triggers.
  assumes the counter model answers beside the design.
*/
`timescale 1ns/10ps
`default_nettype none
`include "daqx_consts.svh"
module testbench;
    logic i_clock, i_rst, i_wr, i_rd, i_clk_sel_10mhz, i_wait_state_sw, i_trigger;
    logic i_wide_variant, o_rdata_valid, o_ctr_wr, o_ctr_rd, o_ctrl_wr;
    logic o_convert, o_conv_enabled, o_burst_busy;
    logic [11:0] i_addr;
    logic [7:0] i_wdata, i_ctr_rdata, o_rdata, o_ctr_wdata, rv;
    logic [3:0] i_burst_length_field;
    logic [1:0] o_gain_code, o_ctr_sel;
    logic [31:0] seed = 32'h0000000c;
    logic [31:0] r;
    int n_errors = 0, checks = 0, ext = 0, blk = 0, bst = 0, np, gap, i;
    int cm[3];
    daqx_ext_regs u_dut (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .i_clk_sel_10mhz, .i_wait_state_sw, .i_wide_variant, .i_burst_length_field,
        .i_trigger, .i_ctr_rdata, .o_rdata, .o_rdata_valid, .o_gain_code, .o_ctr_sel,
        .o_ctr_wr, .o_ctr_rd, .o_ctrl_wr, .o_ctr_wdata, .o_convert, .o_conv_enabled,
        .o_burst_busy);
    daqx_ctr_model u_ctr (.i_clock, .i_rst, .i_ctr_wr(o_ctr_wr), .i_ctr_rd(o_ctr_rd),
        .i_ctr_sel(o_ctr_sel), .i_ctr_wdata(o_ctr_wdata), .o_ctr_rdata(i_ctr_rdata));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [7:0] st();
        return {bst[0], ext[0], 1'b0, ~blk[0], 2'b00, i_wait_state_sw, i_clk_sel_10mhz};
    endfunction : st
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [11:0] a);
        int k;
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        for (k = 0; k < 8; k++) begin
            @(negedge i_clock);
            if (o_rdata_valid === 1'b1) break;
        end
        if (k == 8) begin
            n_errors++;
            results();
        end
        rv = o_rdata;
    endtask : rd
    task automatic trig(int n);
        int k, last;
        np = 0;
        gap = 0;
        last = 0;
        @(posedge i_clock);
        i_trigger <= 1'b1;
        @(posedge i_clock);
        i_trigger <= 1'b0;
        for (k = 0; k < n; k++) begin
            @(negedge i_clock);
            if (o_convert === 1'b1) begin
                if (np > 0) gap = k - last;
                np++;
                last = k;
            end
        end
    endtask : trig
    initial begin
        r = xs();
        {i_rst, i_wr, i_rd, i_trigger, i_wide_variant} = 5'b10000;
        {i_wait_state_sw, i_clk_sel_10mhz} = r[1:0];
        i_addr = 12'h000;
        i_wdata = 8'h00;
        i_burst_length_field = 4'h0;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(`DAQX_OFF_STAT);
        chk("reset status", {6'b000100, r[1:0]}, rv);
        for (i = 0; i < 16; i++) begin
            r = xs();
            if (i == 8) begin
                @(posedge i_clock);
                {i_wait_state_sw, i_clk_sel_10mhz} <= ~{i_wait_state_sw, i_clk_sel_10mhz};
            end
            wr(`DAQX_OFF_CDIS + {10'h000, r[9:8]}, r[7:0]);
            if (r[9:8] == 2'd0) blk = r[6];
            if (r[9:8] == 2'd1) bst = r[6];
            if (r[9:8] == 2'd2) ext = r[6];
            rd(`DAQX_OFF_STAT);
            chk("status", st(), rv);
            chk("conv enabled", ext & ~blk & 1, o_conv_enabled);
        end
        rd(`DAQX_OFF_BEN);
        chk("write-only read", 8'h00, rv);
        for (i = 0; i < 4; i++) begin
            r = xs();
            wr(`DAQX_OFF_GAIN, {r[7:2], i[1:0]});
            rd(`DAQX_OFF_GAIN);
            chk("gain byte", {r[7:2], i[1:0]}, rv);
            chk("gain code", i[1:0], o_gain_code);
        end
        for (i = 0; i < 3; i++) begin
            r = xs();
            cm[i] = r[7:0];
            wr(`DAQX_OFF_CTR0 + i[11:0], r[7:0]);
        end
        wr(`DAQX_OFF_CTRL, 8'h36);
        @(negedge i_clock);
        chk("control strobe", 10'h136, {o_ctr_wr, o_ctrl_wr, o_ctr_wdata});
        for (i = 0; i < 3; i++) begin
            rd(`DAQX_OFF_CTR0 + i[11:0]);
            chk("counter byte", cm[i], rv);
        end
        ext = 1;
        blk = 0;
        bst = 0;
        wr(`DAQX_OFF_MEN, 8'h40);
        wr(`DAQX_OFF_CDIS, 8'h00);
        wr(`DAQX_OFF_BEN, 8'h00);
        trig(6);
        chk("single convert", 1, np);
        wr(`DAQX_OFF_CDIS, 8'h40);
        trig(6);
        chk("blocked convert", 0, np);
        wr(`DAQX_OFF_CDIS, 8'h00);
        wr(`DAQX_OFF_MEN, 8'h00);
        trig(6);
        chk("mode off convert", 0, np);
        wr(`DAQX_OFF_MEN, 8'h40);
        wr(`DAQX_OFF_BEN, 8'h40);
        wr(`DAQX_OFF_GAIN, 8'hfc);
        r = xs();
        i_burst_length_field <= {2'b00, r[1:0]} + 4'h1;
        trig(1000);
        chk("burst count", r[1:0] + 2, np);
        chk("burst gap", `DAQX_BURST12_CYC, gap);
        chk("burst idle", 0, o_burst_busy);
        @(posedge i_clock);
        i_wide_variant <= 1'b1;
        i_burst_length_field <= 4'hf;
        trig(700);
        chk("wide gap", `DAQX_BURST16_CYC, gap);
        chk("burst busy", 1, o_burst_busy);
        wr(`DAQX_OFF_CDIS, 8'h40);
        trig(700);
        chk("blocked burst", 0, np);
        results();
    end
endmodule : testbench
`default_nettype wire
